// ==== rrld_consts.vh ====
// Constants for the ring receive list engine
`ifndef RRLD_CONSTS_VH
`define RRLD_CONSTS_VH
// Command codes
`define RRLD_CMD_RECEIVE 16'h0006
`define RRLD_CMD_TX_HALT 16'h0005
// Command block word offsets in bytes
`define RRLD_CB_ADDR_HI 24'h000002
`define RRLD_CB_ADDR_LO 24'h000004
// Receive list field offsets in bytes, pair stride in bytes and pair count
`define RRLD_LST_LINK_HI 24'h000000
`define RRLD_LST_LINK_LO 24'h000002
`define RRLD_LST_STATUS 24'h000004
`define RRLD_LST_SIZE 24'h000006
`define RRLD_LST_PAIR0 24'h000008
`define RRLD_PAIR_STRIDE 24'h000006
`define RRLD_PAIR_MAX 2'h3
// Status word and count word bits
`define RRLD_STAT_VALID 0
`define RRLD_CNT_MORE 0
// Routing pad length and header length
`define RRLD_ROUTE_PAD 5'h12
`define RRLD_HDR_LEN 5'h0E
// Answer codes
`define RRLD_ANS_COMPLETE 2'h1
`define RRLD_ANS_REJECT 2'h2
`define RRLD_ANS_LIST_ERR 2'h3
`endif

// ==== rrld_engine.v ====
// Receive list DMA engine with transmit halt handling
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rrld_consts.vh"
module rrld_engine (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Command port
  input wire i_cmd_valid,
  input wire [23:0] i_cmd_block_addr,
  input wire i_opened,
  input wire i_pad_routing,
  input wire i_tx_running,
  input wire i_rx_valid_req,
  input wire i_rx_continue_req,
  output reg o_cmd_done,
  output reg [1:0] o_cmd_answer,
  output reg o_tx_halt,
  output reg o_rx_active,
  output reg o_more_lists,
  // Host memory word port
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg [23:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  output reg o_mem_byte,
  input wire i_mem_ack,
  input wire [15:0] i_mem_rdata,
  // Ring frame byte stream
  input wire i_rx_byte_valid,
  input wire [7:0] i_rx_byte,
  input wire i_rx_byte_last,
  input wire i_rx_has_route,
  input wire [4:0] i_rx_route_len,
  output reg o_rx_byte_ready
);

  // ==========================================================
  // States
  localparam S_IDLE = 5'h00;
  localparam S_CMD = 5'h01;
  localparam S_HALT_WORD = 5'h02;
  localparam S_RX_HI = 5'h03;
  localparam S_RX_LO = 5'h04;
  localparam S_LINK_HI = 5'h05;
  localparam S_LINK_LO = 5'h06;
  localparam S_STATUS = 5'h07;
  localparam S_WAIT_VALID = 5'h08;
  localparam S_CNT = 5'h09;
  localparam S_BA_HI = 5'h0A;
  localparam S_BA_LO = 5'h0B;
  localparam S_WAIT_BYTE = 5'h0C;
  localparam S_WRITE = 5'h0D;
  localparam S_SIZE = 5'h0E;
  localparam S_PAUSE = 5'h0F;
  localparam S_DONE = 5'h10;

  reg [4:0] state_reg;
  reg [23:0] cmd_addr_reg;
  reg [7:0] cmd_hi_reg;
  reg [23:0] list_reg;
  reg [23:0] first_list_reg;
  reg [23:0] link_reg;
  reg [1:0] pair_reg;
  reg [15:0] count_reg;
  reg more_reg;
  reg [23:0] buf_reg;
  reg [15:0] size_reg;
  reg [4:0] route_seen_reg;
  reg [4:0] hdr_seen_reg;
  reg frame_open_reg;
  reg frame_end_reg;
  reg [7:0] byte_reg;
  reg byte_pad_reg;
  reg have_byte_reg;
  reg valid_seen_reg;
  reg cont_seen_reg;

  // pair stride, three pairs
  // Address of count word of a pair
  function [23:0] pair_addr;
    input [23:0] base;
    input [1:0] idx;
    begin
      pair_addr = base + `RRLD_LST_PAIR0 + ({22'h000000, idx} * `RRLD_PAIR_STRIDE);
    end
  endfunction

  wire mem_busy = o_mem_rd | o_mem_wr;
  wire mem_done = mem_busy & i_mem_ack;
  wire route_padding = i_pad_routing & (hdr_seen_reg == `RRLD_HDR_LEN)
    & (route_seen_reg < `RRLD_ROUTE_PAD);
  wire real_route = i_rx_has_route & (route_seen_reg < i_rx_route_len);

  // ==========================================================
  // Main sequencer
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      cmd_addr_reg <= 24'h000000;
      cmd_hi_reg <= 8'h00;
      list_reg <= 24'h000000;
      first_list_reg <= 24'h000000;
      link_reg <= 24'h000000;
      pair_reg <= 2'h0;
      count_reg <= 16'h0000;
      more_reg <= 1'b0;
      buf_reg <= 24'h000000;
      size_reg <= 16'h0000;
      route_seen_reg <= 5'h00;
      hdr_seen_reg <= 5'h00;
      frame_open_reg <= 1'b0;
      frame_end_reg <= 1'b0;
      byte_reg <= 8'h00;
      byte_pad_reg <= 1'b0;
      have_byte_reg <= 1'b0;
      valid_seen_reg <= 1'b0;
      cont_seen_reg <= 1'b0;
      o_cmd_done <= 1'b0;
      o_cmd_answer <= 2'h0;
      o_tx_halt <= 1'b0;
      o_rx_active <= 1'b0;
      o_more_lists <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_mem_byte <= 1'b0;
      o_rx_byte_ready <= 1'b0;
    end else begin
      o_cmd_done <= 1'b0;
      o_tx_halt <= 1'b0;
      o_more_lists <= 1'b0;
      o_rx_byte_ready <= 1'b0;
      // Valid and continue requests are latched, clear wins
      if (i_rx_valid_req)
        valid_seen_reg <= 1'b1;
      if (i_rx_continue_req)
        cont_seen_reg <= 1'b1;
      if (mem_done) begin
        o_mem_rd <= 1'b0;
        o_mem_wr <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (i_cmd_valid) begin
            cmd_addr_reg <= i_cmd_block_addr;
            o_mem_rd <= 1'b1;
            o_mem_addr <= i_cmd_block_addr;
            state_reg <= S_CMD;
          end
        end
        S_CMD: begin
          if (mem_done) begin
            if (i_mem_rdata == `RRLD_CMD_TX_HALT) begin
              o_mem_rd <= 1'b1;
              o_mem_addr <= cmd_addr_reg + `RRLD_CB_ADDR_HI;
              state_reg <= S_HALT_WORD;
            end else if (i_mem_rdata == `RRLD_CMD_RECEIVE) begin
              o_mem_rd <= 1'b1;
              o_mem_addr <= cmd_addr_reg + `RRLD_CB_ADDR_HI;
              state_reg <= S_RX_HI;
            end else begin
              state_reg <= o_rx_active ? S_PAUSE : S_IDLE;
            end
          end
        end
        S_HALT_WORD: begin
          if (mem_done) begin
            if (i_tx_running)
              o_tx_halt <= 1'b1;
            state_reg <= o_rx_active ? S_PAUSE : S_IDLE;
          end
        end
        S_RX_HI: begin
          if (mem_done) begin
            cmd_hi_reg <= i_mem_rdata[7:0];
            o_mem_rd <= 1'b1;
            o_mem_addr <= cmd_addr_reg + `RRLD_CB_ADDR_LO;
            state_reg <= S_RX_LO;
          end
        end
        S_RX_LO: begin
          if (mem_done) begin
            o_cmd_done <= 1'b1;
            if (!i_opened || o_rx_active || i_mem_rdata[0]) begin
              o_cmd_answer <= `RRLD_ANS_REJECT;
              state_reg <= o_rx_active ? S_PAUSE : S_IDLE;
            end else begin
              o_cmd_answer <= `RRLD_ANS_COMPLETE;
              o_rx_active <= 1'b1;
              frame_open_reg <= 1'b0;
              list_reg <= {cmd_hi_reg, i_mem_rdata};
              o_mem_rd <= 1'b1;
              o_mem_addr <= {cmd_hi_reg, i_mem_rdata} + `RRLD_LST_LINK_HI;
              state_reg <= S_LINK_HI;
            end
          end
        end
        S_LINK_HI: begin
          if (mem_done) begin
            link_reg[23:16] <= i_mem_rdata[7:0];
            o_mem_rd <= 1'b1;
            o_mem_addr <= list_reg + `RRLD_LST_LINK_LO;
            state_reg <= S_LINK_LO;
          end
        end
        S_LINK_LO: begin
          if (mem_done) begin
            link_reg[15:0] <= i_mem_rdata;
            valid_seen_reg <= i_rx_valid_req;
            o_mem_rd <= 1'b1;
            o_mem_addr <= list_reg + `RRLD_LST_STATUS;
            state_reg <= S_STATUS;
          end
        end
        S_STATUS: begin
          if (mem_done) begin
            if (i_mem_rdata[`RRLD_STAT_VALID]) begin
              pair_reg <= 2'h0;
              o_mem_rd <= 1'b1;
              o_mem_addr <= pair_addr(list_reg, 2'h0);
              state_reg <= S_CNT;
            end else begin
              state_reg <= S_WAIT_VALID;
            end
          end
        end
        S_WAIT_VALID: begin
          if (valid_seen_reg) begin
            valid_seen_reg <= 1'b0;
            o_mem_rd <= 1'b1;
            o_mem_addr <= list_reg + `RRLD_LST_STATUS;
            state_reg <= S_STATUS;
          end
        end
        S_CNT: begin
          if (mem_done) begin
            count_reg <= i_mem_rdata;
            more_reg <= i_mem_rdata[`RRLD_CNT_MORE] & (pair_reg != (`RRLD_PAIR_MAX - 2'h1));
            o_mem_rd <= 1'b1;
            o_mem_addr <= pair_addr(list_reg, pair_reg) + 24'h000002;
            state_reg <= S_BA_HI;
          end
        end
        S_BA_HI: begin
          if (mem_done) begin
            buf_reg[23:16] <= i_mem_rdata[7:0];
            o_mem_rd <= 1'b1;
            o_mem_addr <= pair_addr(list_reg, pair_reg) + 24'h000004;
            state_reg <= S_BA_LO;
          end
        end
        S_BA_LO: begin
          if (mem_done) begin
            buf_reg[15:0] <= i_mem_rdata;
            if (!frame_open_reg) begin
              first_list_reg <= list_reg;
              size_reg <= 16'h0000;
              hdr_seen_reg <= 5'h00;
              route_seen_reg <= 5'h00;
              frame_end_reg <= 1'b0;
              frame_open_reg <= 1'b1;
            end
            state_reg <= S_WAIT_BYTE;
          end
        end
        S_WAIT_BYTE: begin
          if (frame_end_reg) begin
            o_mem_wr <= 1'b1;
            o_mem_byte <= 1'b0;
            o_mem_addr <= first_list_reg + `RRLD_LST_SIZE;
            o_mem_wdata <= size_reg;
            state_reg <= S_SIZE;
          end else if (count_reg == 16'h0000) begin
            if (more_reg) begin
              pair_reg <= pair_reg + 2'h1;
              o_mem_rd <= 1'b1;
              o_mem_addr <= pair_addr(list_reg, pair_reg + 2'h1);
              state_reg <= S_CNT;
            end else if (link_reg[0]) begin
              // Buffers exhausted at chain end
              o_cmd_answer <= `RRLD_ANS_LIST_ERR;
              o_cmd_done <= 1'b1;
              o_rx_active <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              list_reg <= link_reg;
              o_mem_rd <= 1'b1;
              o_mem_addr <= link_reg + `RRLD_LST_LINK_HI;
              state_reg <= S_LINK_HI;
            end
          end else if (route_padding && !real_route) begin
            route_seen_reg <= route_seen_reg + 5'h01;
            size_reg <= size_reg + 16'h0001;
            buf_reg <= buf_reg + 24'h000001;
            count_reg <= count_reg - 16'h0001;
          end else if (i_rx_byte_valid) begin
            o_rx_byte_ready <= 1'b1;
            byte_reg <= i_rx_byte;
            frame_end_reg <= i_rx_byte_last;
            if (hdr_seen_reg != `RRLD_HDR_LEN)
              hdr_seen_reg <= hdr_seen_reg + 5'h01;
            else if (real_route)
              route_seen_reg <= route_seen_reg + 5'h01;
            o_mem_wr <= 1'b1;
            o_mem_byte <= 1'b1;
            o_mem_addr <= buf_reg;
            o_mem_wdata <= {8'h00, i_rx_byte};
            state_reg <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (mem_done) begin
            size_reg <= size_reg + 16'h0001;
            buf_reg <= buf_reg + 24'h000001;
            count_reg <= count_reg - 16'h0001;
            state_reg <= S_WAIT_BYTE;
          end
        end
        S_SIZE: begin
          if (mem_done) begin
            frame_open_reg <= 1'b0;
            if (link_reg[0]) begin
              o_more_lists <= 1'b1;
              cont_seen_reg <= i_rx_continue_req;
              state_reg <= S_PAUSE;
            end else begin
              list_reg <= link_reg;
              o_mem_rd <= 1'b1;
              o_mem_addr <= link_reg + `RRLD_LST_LINK_HI;
              state_reg <= S_LINK_HI;
            end
          end
        end
        S_PAUSE: begin
          if (cont_seen_reg) begin
            cont_seen_reg <= 1'b0;
            o_mem_rd <= 1'b1;
            o_mem_addr <= list_reg + `RRLD_LST_LINK_HI;
            state_reg <= S_LINK_HI;
          end else if (i_cmd_valid) begin
            // Commands still taken while paused
            cmd_addr_reg <= i_cmd_block_addr;
            o_mem_rd <= 1'b1;
            o_mem_addr <= i_cmd_block_addr;
            state_reg <= S_CMD;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // rrld_engine

// ==== rrld_chk.sv ====
// Port checker for the receive list engine
`timescale 1ns/1ps
`include "rrld_consts.vh"
module rrld_chk (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Observed ports
  input wire i_opened,
  input wire i_tx_running,
  input wire i_mem_ack,
  input wire o_cmd_done,
  input wire [1:0] o_cmd_answer,
  input wire o_tx_halt,
  input wire o_rx_active,
  input wire o_more_lists,
  input wire o_mem_rd,
  input wire o_mem_wr,
  input wire [23:0] o_mem_addr,
  input wire [15:0] o_mem_wdata
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================
  // Memory access steps
  sequence rd_wait_s; o_mem_rd && !i_mem_ack; endsequence
  sequence wr_wait_s; o_mem_wr && !i_mem_ack; endsequence
  sequence rd_held_s; o_mem_rd && $stable(o_mem_addr); endsequence
  sequence wr_held_s; o_mem_wr && $stable(o_mem_addr) && $stable(o_mem_wdata); endsequence
  // ==========================================
  // Assertions
  rd_request_hold_a: assert property (rd_wait_s |=> rd_held_s)
    else $error("read request dropped early");
  wr_request_hold_a: assert property (wr_wait_s |=> wr_held_s)
    else $error("write request dropped early");
  one_access_a: assert property (!(o_mem_rd && o_mem_wr))
    else $error("read and write together");
  halt_pulse_a: assert property (o_tx_halt |=> !o_tx_halt)
    else $error("halt longer than one cycle");
  halt_idle_a: assert property (o_tx_halt |-> $past(i_tx_running))
    else $error("halt without running transmit");
  open_reject_a: assert property (o_cmd_done && !$past(i_opened) |-> o_cmd_answer != 2'h1)
    else $error("command completed while not opened");
  busy_reject_a: assert property (o_cmd_done && $past(o_rx_active) |-> o_cmd_answer != 2'h1)
    else $error("second receive completed");
  write_active_a: assert property (o_mem_wr |-> o_rx_active)
    else $error("write without receive running");
  more_active_a: assert property (o_more_lists |-> o_rx_active ##1 o_rx_active)
    else $error("receive ended at chain end");
endmodule // rrld_chk
bind rrld_engine rrld_chk u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_opened(i_opened),
  .i_tx_running(i_tx_running), .i_mem_ack(i_mem_ack), .o_cmd_done(o_cmd_done),
  .o_cmd_answer(o_cmd_answer), .o_tx_halt(o_tx_halt), .o_rx_active(o_rx_active),
  .o_more_lists(o_more_lists), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));

// ==== rrld_host_mem.sv ====
// Host memory model answering the engine's word port
`timescale 1ns/1ps
module rrld_host_mem (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Word port
  input wire i_rd,
  input wire i_wr,
  input wire [23:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_byte,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [7:0] mem [0:511];
  logic [1:0] dly;
  logic slow;
  wire [8:0] a = i_addr[8:0];
  // ==========================================
  // Prompt and slow answers alternate
  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    dly = 2'h0;
    slow = 1'b0;
  end
  always @(posedge i_clock) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_rst) begin
      dly <= 2'h0;
    end else if ((i_rd || i_wr) && !o_ack) begin
      if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else begin
        o_ack <= 1'b1;
        slow <= ~slow;
        dly <= slow ? 2'h2 : 2'h0;
        if (i_rd) begin
          o_rdata <= {mem[a], mem[a + 9'h1]};
        end
        if (i_wr && i_byte) begin
          mem[a] <= i_wdata[7:0];
        end else if (i_wr) begin
          {mem[a], mem[a + 9'h1]} <= i_wdata;
        end
      end
    end
  end
endmodule // rrld_host_mem

// ==== tb_top.sv ====
// Command and frame tests for the receive list engine
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic i_clock = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_opened = 1'b0;
  logic i_tx_running = 1'b0, i_rx_valid_req = 1'b0, i_rx_continue_req = 1'b0;
  logic i_rx_byte_valid = 1'b0, i_rx_byte_last = 1'b0;
  logic [23:0] i_cmd_block_addr = 24'h000000;
  logic [7:0] i_rx_byte = 8'h00;
  wire o_cmd_done, o_tx_halt, o_rx_active, o_more_lists, o_mem_rd, o_mem_wr, o_mem_byte;
  wire i_mem_ack, o_rx_byte_ready;
  wire [1:0] o_cmd_answer;
  wire [23:0] o_mem_addr;
  wire [15:0] o_mem_wdata, i_mem_rdata;
  int mismatches = 0, cmp_count = 0, done_cnt = 0, halt_cnt = 0, more_cnt = 0, n;
  logic [1:0] ans;
  rrld_engine dut (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_block_addr(i_cmd_block_addr), .i_opened(i_opened), .i_pad_routing(1'b0),
    .i_tx_running(i_tx_running), .i_rx_valid_req(i_rx_valid_req),
    .i_rx_continue_req(i_rx_continue_req), .o_cmd_done(o_cmd_done),
    .o_cmd_answer(o_cmd_answer), .o_tx_halt(o_tx_halt), .o_rx_active(o_rx_active),
    .o_more_lists(o_more_lists), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_byte(o_mem_byte),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .i_rx_byte_valid(i_rx_byte_valid),
    .i_rx_byte(i_rx_byte), .i_rx_byte_last(i_rx_byte_last), .i_rx_has_route(1'b0),
    .i_rx_route_len(5'h00), .o_rx_byte_ready(o_rx_byte_ready));
  rrld_host_mem host (.i_clock(i_clock), .i_rst(i_rst), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_byte(o_mem_byte), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));
  // ==========================================
  // Clock and pulse counters
  initial begin
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (o_cmd_done) begin
      done_cnt++;
      ans = o_cmd_answer;
    end
    if (o_tx_halt) halt_cnt++;
    if (o_more_lists) more_cnt++;
  end
  // ==========================================
  // Tasks
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic put16(input int a, input logic [15:0] v);
    host.mem[a] = v[15:8];
    host.mem[a + 1] = v[7:0];
  endtask
  task automatic wait_cnt(ref int c, input int was, input int lim, input string what);
    int i;
    for (i = 0; i < lim && c == was; i++) @(posedge i_clock);
    if (c == was) begin
      $display("unexpected %s missing", what);
      mismatches++;
      close_out();
    end
  endtask
  task automatic cmd(input logic [23:0] a);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_block_addr <= a;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic last);
    int i;
    i_rx_byte_valid <= 1'b1;
    i_rx_byte <= b;
    i_rx_byte_last <= last;
    for (i = 0; i < 200 && !o_rx_byte_ready; i++) @(posedge i_clock);
    if (!o_rx_byte_ready) wait_cnt(n, n, 0, "byte ready");
    @(posedge i_clock);
  endtask
  // ==========================================
  // Tests
  initial begin
    for (int i = 0; i < 512; i++) host.mem[i] = 8'hEE;
    put16(16'h40, 16'h0006); put16(16'h42, 16'hAB00); put16(16'h44, 16'h0080);
    put16(16'h50, 16'h0005); put16(16'h52, 16'h1234); put16(16'h54, 16'h5678);
    put16(16'h60, 16'h0006); put16(16'h62, 16'h0000); put16(16'h64, 16'h0081);
    put16(16'h80, 16'h0000); put16(16'h82, 16'h0001); put16(16'h84, 16'h0001);
    put16(16'h86, 16'h0000); put16(16'h88, 16'h0010); put16(16'h8A, 16'h0000);
    put16(16'h8C, 16'h00C0);
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    cmd(24'h000040);
    wait_cnt(done_cnt, 0, 100, "done");
    `CHK("not opened", 2'h2, ans)
    $display("test not opened done");
    i_opened <= 1'b1;
    cmd(24'h000050);
    repeat (60) @(posedge i_clock);
    `CHK("idle halt", 0, halt_cnt + done_cnt - 1)
    i_tx_running <= 1'b1;
    cmd(24'h000050);
    wait_cnt(halt_cnt, 0, 100, "halt");
    i_tx_running <= 1'b0;
    $display("test halt done");
    n = done_cnt;
    cmd(24'h000060);
    wait_cnt(done_cnt, n, 100, "done");
    `CHK("odd list", 2'h2, ans)
    n = done_cnt;
    cmd(24'h000040);
    wait_cnt(done_cnt, n, 100, "done");
    `CHK("receive", 2'h1, ans)
    `CHK("active", 1'b1, o_rx_active)
    i_rx_valid_req <= 1'b1;
    @(posedge i_clock);
    i_rx_valid_req <= 1'b0;
    for (int i = 0; i < 16; i++) send(8'h10 + i[7:0], i == 15);
    i_rx_byte_valid <= 1'b0;
    wait_cnt(more_cnt, 0, 400, "more lists");
    for (int i = 0; i < 16; i++) `CHK("frame byte", 8'h10 + i[7:0], host.mem[8'hC0 + i])
    `CHK("past count", 8'hEE, host.mem[8'hD0])
    `CHK("size", 16'h0010, {host.mem[8'h86], host.mem[8'h87]})
    `CHK("link", 32'h00000001, {host.mem[8'h80], host.mem[8'h81], host.mem[8'h82],
      host.mem[8'h83]})
    `CHK("count", 16'h0010, {host.mem[8'h88], host.mem[8'h89]})
    `CHK("still active", 1'b1, o_rx_active)
    $display("test frame done");
    n = done_cnt;
    cmd(24'h000040);
    wait_cnt(done_cnt, n, 100, "done");
    `CHK("busy", 2'h2, ans)
    i_rx_continue_req <= 1'b1;
    @(posedge i_clock);
    i_rx_continue_req <= 1'b0;
    repeat (20) @(posedge i_clock);
    $display("test busy done");
    close_out();
  end
endmodule // tb_top
